// ### common/pin_mux_pkg.sv
// Purpose: Types shared by the pin mux slice.
// Assumes: Mode codes follow the header.
// Notes: Holds types only.
package pin_mux_pkg;
   typedef logic [3:0] pad_field_t;
   typedef logic [1:0] serial_mode_t;
endpackage

// ### common/pin_mux_regs.svh
// Purpose: Field positions, codes and reset values for the pin mux slice.
// Assumes: Pad config fields are four bits wide, one per pin.
// Notes: Definitions only.
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH
`define PAD_FIELD_W 4
`define PAD_CFG_ALT_OUT 4'h9
`define PAD_CFG_ALT_OD 4'hD
`define PAD_CFG_RESET 4'h4
`define A7_FIELD_LSB 12
`define A1_FIELD_LSB 4
`define D1_FIELD_LSB 4
`define D2_FIELD_LSB 8
`define D3_FIELD_LSB 12
`define B3_FIELD_LSB 12
`define B4_FIELD_LSB 0
`define DBG_REGEN_DIS_BIT 4
`define SPI_MASTER_BIT 4
`define UART_HANDSHAKE_BIT 5
`define TIM2_REMAP_CH3_BIT 6
`define TIM2_REMAP_CH4_BIT 7
`define MODE_W 2
`define MODE_DISABLED 2'h0
`define MODE_UART 2'h1
`define MODE_SPI 2'h2
`define MODE_TWI 2'h3
`endif

// ### hw/serial_timer_pin_mux_slice.sv
// Purpose: Alternate function selection for seven general purpose pins.
// Assumes: All inputs are synchronous to clk; configuration is static.
// Notes: Outputs are registered; pad enables are high while driving.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_regs.svh"
module serial_timer_pin_mux_slice #(
   parameter int NUM_PINS = 32,
   parameter int SEL_W = 5
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic debug_pin_config_regen_dis,
   input wire logic [15:0] porta_high_pad_config,
   input wire logic [15:0] porta_low_pad_config,
   input wire logic [15:0] portd_low_pad_config,
   input wire logic [15:0] portb_low_pad_config,
   input wire logic [15:0] portb_high_pad_config,
   input wire logic [7:0] timer2_remap_option,
   input wire logic timer1_ch4_out_en,
   input wire logic timer2_ch3_out_en,
   input wire logic timer2_ch4_out_en,
   input wire logic [1:0] sercon3_mode_select,
   input wire logic [7:0] sercon3_spi_config,
   input wire logic [7:0] sercon3_uart_config,
   input wire logic [1:0] sercon1_mode_select,
   input wire logic [7:0] sercon1_spi_config,
   input wire logic [7:0] sercon1_uart_config,
   input wire logic [NUM_PINS-1:0] gpio_out,
   input wire logic [NUM_PINS-1:0] gpio_dir,
   input wire logic [NUM_PINS-1:0] pad_in,
   input wire logic [SEL_W-1:0] ext_int_c_pin_select,
   input wire logic [SEL_W-1:0] ext_int_d_pin_select,
   input wire logic [SEL_W-1:0] porta_pin_seven_idx,
   input wire logic [SEL_W-1:0] porta_pin_one_idx,
   input wire logic [SEL_W-1:0] portd_pin_one_idx,
   input wire logic [SEL_W-1:0] portd_pin_two_idx,
   input wire logic [SEL_W-1:0] portd_pin_three_idx,
   input wire logic [SEL_W-1:0] portb_pin_three_idx,
   input wire logic [SEL_W-1:0] portb_pin_four_idx,
   input wire logic regulator_enable,
   input wire logic timer1_channel4_out,
   input wire logic timer2_channel3_out,
   input wire logic timer2_channel4_out,
   input wire logic sercon3_spi_data_out,
   input wire logic sercon3_twi_data_out,
   input wire logic sercon3_twi_clock_out,
   input wire logic sercon3_uart_tx,
   input wire logic sercon3_spi_clock_out,
   input wire logic sercon1_spi_clock_out,
   input wire logic sercon1_request_to_send_n,
   output logic [NUM_PINS-1:0] pad_out,
   output logic [NUM_PINS-1:0] pad_oe,
   output logic timer1_channel4_in,
   output logic timer2_channel3_in,
   output logic timer2_channel4_in,
   output logic sercon3_spi_data_in,
   output logic sercon3_uart_rx,
   output logic sercon3_twi_data_in,
   output logic sercon3_twi_clock_in,
   output logic sercon3_clear_to_send_n,
   output logic sercon3_spi_clock_in,
   output logic sercon1_clear_to_send_n,
   output logic sercon1_spi_clock_in,
   output logic sercon1_slave_select_n,
   output logic ext_interrupt_c,
   output logic ext_interrupt_d
);
   // ----------------------------------------------------------------------
   // Pad field decode
   // ----------------------------------------------------------------------
   wire pin_mux_pkg::pad_field_t a7_f =
      porta_high_pad_config[`A7_FIELD_LSB +: `PAD_FIELD_W];
   wire pin_mux_pkg::pad_field_t a1_f =
      porta_low_pad_config[`A1_FIELD_LSB +: `PAD_FIELD_W];
   wire pin_mux_pkg::pad_field_t d1_f =
      portd_low_pad_config[`D1_FIELD_LSB +: `PAD_FIELD_W];
   wire pin_mux_pkg::pad_field_t d2_f =
      portd_low_pad_config[`D2_FIELD_LSB +: `PAD_FIELD_W];
   wire pin_mux_pkg::pad_field_t d3_f =
      portd_low_pad_config[`D3_FIELD_LSB +: `PAD_FIELD_W];
   wire pin_mux_pkg::pad_field_t b3_f =
      portb_low_pad_config[`B3_FIELD_LSB +: `PAD_FIELD_W];
   wire pin_mux_pkg::pad_field_t b4_f =
      portb_high_pad_config[`B4_FIELD_LSB +: `PAD_FIELD_W];
   wire a7_alt = (a7_f == `PAD_CFG_ALT_OUT);
   wire a1_alt = (a1_f == `PAD_CFG_ALT_OUT);
   wire d1_alt = (d1_f == `PAD_CFG_ALT_OUT);
   wire d1_od = (d1_f == `PAD_CFG_ALT_OD);
   wire d2_od = (d2_f == `PAD_CFG_ALT_OD);
   wire d3_alt = (d3_f == `PAD_CFG_ALT_OUT);
   wire b3_alt = (b3_f == `PAD_CFG_ALT_OUT);
   wire b4_alt = (b4_f == `PAD_CFG_ALT_OUT);

   // ----------------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------------
   wire sc3_spi = (sercon3_mode_select == `MODE_SPI);
   wire sc3_twi = (sercon3_mode_select == `MODE_TWI);
   wire sc3_uart = (sercon3_mode_select == `MODE_UART);
   wire sc3_master = sercon3_spi_config[`SPI_MASTER_BIT];
   wire sc3_hs = sercon3_uart_config[`UART_HANDSHAKE_BIT];
   wire sc1_spi = (sercon1_mode_select == `MODE_SPI);
   wire sc1_uart = (sercon1_mode_select == `MODE_UART);
   wire sc1_master = sercon1_spi_config[`SPI_MASTER_BIT];
   wire sc1_hs = sercon1_uart_config[`UART_HANDSHAKE_BIT];
   wire remap3 = timer2_remap_option[`TIM2_REMAP_CH3_BIT];
   wire remap4 = timer2_remap_option[`TIM2_REMAP_CH4_BIT];
   wire regen_on = !debug_pin_config_regen_dis;

   // ----------------------------------------------------------------------
   // Pin input sampling
   // ----------------------------------------------------------------------
   wire in_a7 = pad_in[porta_pin_seven_idx];
   wire in_a1 = pad_in[porta_pin_one_idx];
   wire in_d1 = pad_in[portd_pin_one_idx];
   wire in_d2 = pad_in[portd_pin_two_idx];
   wire in_d3 = pad_in[portd_pin_three_idx];
   wire in_b3 = pad_in[portb_pin_three_idx];
   wire in_b4 = pad_in[portb_pin_four_idx];

   // ----------------------------------------------------------------------
   // Alternate output selection per special pin
   // ----------------------------------------------------------------------
   // Open-drain pins drive low only; a high level releases the pad.
   wire a7_t1 = !regen_on && timer1_ch4_out_en && a7_alt;
   wire a7_own = regen_on || a7_t1;
   wire a7_val = regen_on ? 1'b0 : timer1_channel4_out;
   wire a7_en = regen_on ? !regulator_enable : 1'b1;
   wire d1_spi = sc3_spi && d1_alt;
   wire d1_twi = sc3_twi && d1_od;
   wire d1_uart = sc3_uart && d1_alt;
   wire d1_own = d1_spi || d1_twi || d1_uart;
   wire d1_val = d1_twi ? 1'b0 : (d1_spi ? sercon3_spi_data_out : sercon3_uart_tx);
   wire d1_en = d1_twi ? !sercon3_twi_data_out : 1'b1;
   wire d2_own = sc3_twi && d2_od;
   wire d2_en = !sercon3_twi_clock_out;
   wire d3_own = sc3_spi && sc3_master && d3_alt;
   wire a1_own = !remap3 && timer2_ch3_out_en && a1_alt;
   wire b3_t2 = remap3 && timer2_ch3_out_en && b3_alt;
   wire b3_sc = (!timer2_ch3_out_en || !remap3) && sc1_spi && sc1_master && b3_alt;
   wire b3_val = b3_t2 ? timer2_channel3_out : sercon1_spi_clock_out;
   wire b4_t2 = remap4 && timer2_ch4_out_en && b4_alt;
   wire b4_sc = (!timer2_ch4_out_en || !remap4) && sc1_uart && sc1_hs && b4_alt;
   wire b4_val = b4_t2 ? timer2_channel4_out : sercon1_request_to_send_n;

   logic [NUM_PINS-1:0] next_out;
   logic [NUM_PINS-1:0] next_oe;
   always_comb begin
      next_out = gpio_out;
      next_oe = gpio_dir;
      if (a7_own) begin
         next_out[porta_pin_seven_idx] = a7_val;
         next_oe[porta_pin_seven_idx] = a7_en;
      end
      if (a1_own) begin
         next_out[porta_pin_one_idx] = timer2_channel3_out;
         next_oe[porta_pin_one_idx] = 1'b1;
      end
      if (d1_own) begin
         next_out[portd_pin_one_idx] = d1_val;
         next_oe[portd_pin_one_idx] = d1_en;
      end
      if (d2_own) begin
         next_out[portd_pin_two_idx] = 1'b0;
         next_oe[portd_pin_two_idx] = d2_en;
      end
      if (d3_own) begin
         next_out[portd_pin_three_idx] = sercon3_spi_clock_out;
         next_oe[portd_pin_three_idx] = 1'b1;
      end
      if (b3_t2 || b3_sc) begin
         next_out[portb_pin_three_idx] = b3_val;
         next_oe[portb_pin_three_idx] = 1'b1;
      end
      if (b4_t2 || b4_sc) begin
         next_out[portb_pin_four_idx] = b4_val;
         next_oe[portb_pin_four_idx] = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Peripheral input selection
   // ----------------------------------------------------------------------
   wire n_t1c4 = in_a7;
   wire n_t2c3 = remap3 ? in_b3 : in_a1;
   wire n_t2c4 = remap4 ? in_b4 : 1'b0;
   wire n_sc3_din = sc3_spi ? in_d2 : 1'b0;
   wire n_sc3_rx = sc3_uart ? in_d2 : 1'b1;
   wire n_sc3_sda = sc3_twi ? in_d1 : 1'b1;
   wire n_sc3_scl = sc3_twi ? in_d2 : 1'b1;
   wire n_sc3_cts = (sc3_uart && sc3_hs) ? in_d3 : 1'b0;
   wire n_sc3_clk = (sc3_spi && !sc3_master) ? in_d3 : 1'b0;
   wire n_sc1_cts = (sc1_uart && sc1_hs) ? in_b3 : 1'b0;
   wire n_sc1_clk = (sc1_spi && !sc1_master) ? in_b3 : 1'b0;
   wire n_sc1_ss = (sc1_spi && !sc1_master) ? in_b4 : 1'b1;
   wire n_irq_c = pad_in[ext_int_c_pin_select];
   wire n_irq_d = pad_in[ext_int_d_pin_select];

   // ----------------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pad_out <= '0;
         pad_oe <= '0;
         timer1_channel4_in <= 1'b0;
         timer2_channel3_in <= 1'b0;
         timer2_channel4_in <= 1'b0;
         sercon3_spi_data_in <= 1'b0;
         sercon3_uart_rx <= 1'b1;
         sercon3_twi_data_in <= 1'b1;
         sercon3_twi_clock_in <= 1'b1;
         sercon3_clear_to_send_n <= 1'b0;
         sercon3_spi_clock_in <= 1'b0;
         sercon1_clear_to_send_n <= 1'b0;
         sercon1_spi_clock_in <= 1'b0;
         sercon1_slave_select_n <= 1'b1;
         ext_interrupt_c <= 1'b0;
         ext_interrupt_d <= 1'b0;
      end else if (clk_en) begin
         pad_out <= next_out;
         pad_oe <= next_oe;
         timer1_channel4_in <= n_t1c4;
         timer2_channel3_in <= n_t2c3;
         timer2_channel4_in <= n_t2c4;
         sercon3_spi_data_in <= n_sc3_din;
         sercon3_uart_rx <= n_sc3_rx;
         sercon3_twi_data_in <= n_sc3_sda;
         sercon3_twi_clock_in <= n_sc3_scl;
         sercon3_clear_to_send_n <= n_sc3_cts;
         sercon3_spi_clock_in <= n_sc3_clk;
         sercon1_clear_to_send_n <= n_sc1_cts;
         sercon1_spi_clock_in <= n_sc1_clk;
         sercon1_slave_select_n <= n_sc1_ss;
         ext_interrupt_c <= n_irq_c;
         ext_interrupt_d <= n_irq_d;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_regen_od_drive: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && regen_on && !regulator_enable |=> !pad_out[$past(porta_pin_seven_idx)])
      else $error("regulator enable not driven low");
   a_timer1_gate: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && !regen_on && !(timer1_ch4_out_en && a7_alt) && !gpio_dir[porta_pin_seven_idx]
      |=> !pad_oe[$past(porta_pin_seven_idx)])
      else $error("timer 1 drives pin without enable");
   a_t1_capture: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en |=> timer1_channel4_in == $past(in_a7))
      else $error("timer 1 capture not from pin seven");
   a_twi_od: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && d1_twi |=> pad_out[$past(portd_pin_one_idx)] == 1'b0)
      else $error("twi data driven high");
   a_sc3_cts: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && !(sc3_uart && sc3_hs) |=> !sercon3_clear_to_send_n)
      else $error("cts routed without handshake");
   a_t2c3_in: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && remap3 |=> timer2_channel3_in == $past(in_b3))
      else $error("timer 2 channel 3 capture wrong pin");
   a_b3_prio: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && b3_t2 |=> pad_out[$past(portb_pin_three_idx)] == $past(timer2_channel3_out))
      else $error("timer 2 lost port b pin three");
   a_slave_sel: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && sc1_spi && !sc1_master |=> sercon1_slave_select_n == $past(in_b4))
      else $error("slave select not from pin four");
endmodule
`default_nettype wire

// ### tb/pin_partner.sv
// Purpose: Pads and the devices beyond them for the pin mux slice.
// Assumes: Every pad has a pull-up; all drivers are wired-and.
// Notes: ext_oe high means the far device drives ext_val.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   input wire logic [31:0] pad_out,
   input wire logic [31:0] pad_oe,
   input wire logic [31:0] ext_val,
   input wire logic [31:0] ext_oe,
   output logic [31:0] pad_in
);
   // A released line reads high through its pull-up.
   assign pad_in = (pad_oe & pad_out | ~pad_oe) & (ext_oe & ext_val | ~ext_oe);
endmodule
`default_nettype wire

// ### tb/test_serial_timer_pin_mux_slice.sv
// Purpose: Self-checking bench for the pin mux slice.
// Assumes: Outputs settle within two clock cycles of an input change.
// Notes: Inputs change at the falling edge only.
`timescale 1ns/1ps
`default_nettype none
module test_serial_timer_pin_mux_slice;
   localparam int a7 = 7, a1 = 1, d1 = 25, d2 = 26, d3 = 27, b3 = 11, b4 = 12;
   logic clk, reset_n, clk_en, regen_dis, t1_en, t23_en, t24_en, reg_en, t1_o, t23_o, t24_o;
   logic s3_sdo, s3_twd, s3_twc, s3_tx, s3_sck, s1_sck, s1_rts, t1_i, t23_i, t24_i, s3_sdi;
   logic s3_rx, s3_twdi, s3_twci, s3_cts, s3_scki, s1_cts, s1_scki, s1_ss, irq_c, irq_d;
   logic [15:0] pa_hi, pa_lo, pd_lo, pb_lo, pb_hi;
   logic [7:0] remap, s3_spi, s3_uart, s1_spi, s1_uart;
   logic [1:0] s3_mode, s1_mode;
   logic [31:0] g_out, g_dir, pad_in, pad_out, pad_oe, ext_val, ext_oe;
   logic [4:0] sel_c, sel_d, a7_idx, a1_idx;
   int mismatches, tests_run;
   serial_timer_pin_mux_slice DUT (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
      .debug_pin_config_regen_dis(regen_dis), .porta_high_pad_config(pa_hi),
      .porta_low_pad_config(pa_lo), .portd_low_pad_config(pd_lo),
      .portb_low_pad_config(pb_lo), .portb_high_pad_config(pb_hi),
      .timer2_remap_option(remap), .timer1_ch4_out_en(t1_en), .timer2_ch3_out_en(t23_en),
      .timer2_ch4_out_en(t24_en), .sercon3_mode_select(s3_mode), .sercon3_spi_config(s3_spi),
      .sercon3_uart_config(s3_uart), .sercon1_mode_select(s1_mode),
      .sercon1_spi_config(s1_spi), .sercon1_uart_config(s1_uart), .gpio_out(g_out),
      .gpio_dir(g_dir), .pad_in(pad_in), .ext_int_c_pin_select(sel_c),
      .ext_int_d_pin_select(sel_d), .porta_pin_seven_idx(a7_idx), .porta_pin_one_idx(a1_idx),
      .portd_pin_one_idx(5'h19), .portd_pin_two_idx(5'h1A), .portd_pin_three_idx(5'h1B),
      .portb_pin_three_idx(5'h0B), .portb_pin_four_idx(5'h0C), .regulator_enable(reg_en),
      .timer1_channel4_out(t1_o), .timer2_channel3_out(t23_o), .timer2_channel4_out(t24_o),
      .sercon3_spi_data_out(s3_sdo), .sercon3_twi_data_out(s3_twd),
      .sercon3_twi_clock_out(s3_twc), .sercon3_uart_tx(s3_tx), .sercon3_spi_clock_out(s3_sck),
      .sercon1_spi_clock_out(s1_sck), .sercon1_request_to_send_n(s1_rts), .pad_out(pad_out),
      .pad_oe(pad_oe), .timer1_channel4_in(t1_i), .timer2_channel3_in(t23_i),
      .timer2_channel4_in(t24_i), .sercon3_spi_data_in(s3_sdi), .sercon3_uart_rx(s3_rx),
      .sercon3_twi_data_in(s3_twdi), .sercon3_twi_clock_in(s3_twci),
      .sercon3_clear_to_send_n(s3_cts), .sercon3_spi_clock_in(s3_scki),
      .sercon1_clear_to_send_n(s1_cts), .sercon1_spi_clock_in(s1_scki),
      .sercon1_slave_select_n(s1_ss), .ext_interrupt_c(irq_c), .ext_interrupt_d(irq_d));
   pin_partner far_side (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val),
      .ext_oe(ext_oe), .pad_in(pad_in));
   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic settle();
      repeat (2) @(negedge clk);
   endtask
   task automatic chk(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         $display("BAD %s expected %b seen %b", what, exp, got);
         mismatches++;
      end
   endtask
   task automatic defaults();
      {regen_dis, t1_en, t23_en, t24_en, t1_o, t23_o, t24_o, s3_sdo, s3_tx} = 9'h000;
      {s3_twd, s3_twc, s3_sck, s1_sck, s1_rts} = 5'h1F;
      {pa_hi, pa_lo, pd_lo, pb_lo, pb_hi} = {5{16'h4444}};
      {remap, s3_spi, s3_uart, s1_spi, s1_uart} = 40'h00_0000_0000;
      {s3_mode, s1_mode} = 4'h0;
      {g_out, g_dir, ext_val, ext_oe} = {4{32'h0000_0000}};
      {sel_c, sel_d, a7_idx, a1_idx} = 20'h000E1;
   endtask
   task automatic end_of_test();
      $display("Counts: %0d compares, %0d mismatches", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic test_regulator();
      chk("reg oe", 1'b1, pad_oe[a7]);
      chk("reg out", 1'b0, pad_out[a7]);
      reg_en = 1'b1;
      settle();
      chk("reg release", 1'b0, pad_oe[a7]);
      {regen_dis, g_dir[a7], g_out[a7], reg_en} = 4'hE;
      settle();
      chk("a7 gpio oe", 1'b1, pad_oe[a7]);
      chk("a7 gpio out", 1'b1, pad_out[a7]);
      $display("test regulator done");
   endtask
   task automatic test_timer1();
      {regen_dis, t1_en, pa_hi} = {2'h3, 16'h9444};
      for (int v = 0; v < 2; v++) begin
         t1_o = v[0];
         settle();
         chk("t1 out", v[0], pad_out[a7]);
         chk("t1 oe", 1'b1, pad_oe[a7]);
      end
      {t1_en, ext_oe[a7], ext_val[a7]} = 3'h2;
      settle();
      chk("t1 off oe", 1'b0, pad_oe[a7]);
      chk("t1 capture", 1'b0, t1_i);
      $display("test timer1 done");
   endtask
   task automatic test_sercon3_spi();
      {s3_mode, pd_lo, ext_oe[d2]} = {2'h2, 16'h9494, 1'b1};
      for (int m = 0; m < 2; m++) begin
         for (int v = 0; v < 2; v++) begin
            {s3_spi, s3_sdo, s3_sck, ext_val[d2], ext_val[d3], ext_oe[d3]} =
               {3'h0, m[0], 4'h0, v[0], v[0], v[0], v[0], !m[0]};
            settle();
            chk("s3 sdo", v[0], pad_out[d1]);
            chk("s3 sdi", v[0], s3_sdi);
            chk("s3 sck oe", m[0], pad_oe[d3]);
            chk("s3 sck", v[0], m[0] ? pad_out[d3] : s3_scki);
         end
      end
      $display("test sercon3 spi done");
   endtask
   task automatic test_sercon3_uart_twi();
      {s3_mode, s3_uart, pd_lo, ext_oe[d2], ext_oe[d3]} = {2'h1, 8'h20, 16'h4494, 2'h3};
      for (int v = 0; v < 2; v++) begin
         {s3_tx, ext_val[d2], ext_val[d3]} = {v[0], v[0], !v[0]};
         settle();
         chk("s3 tx", v[0], pad_out[d1]);
         chk("s3 rx", v[0], s3_rx);
         chk("s3 cts", !v[0], s3_cts);
      end
      {s3_mode, pd_lo, ext_oe} = {2'h3, 16'h4DD4, 32'h0000_0000};
      for (int v = 0; v < 2; v++) begin
         {s3_twd, s3_twc} = {v[0], v[0]};
         settle();
         chk("twi data oe", !v[0], pad_oe[d1]);
         chk("twi clock oe", !v[0], pad_oe[d2]);
         chk("twi data in", v[0], s3_twdi);
         chk("twi clock in", v[0], s3_twci);
      end
      $display("test sercon3 uart twi done");
   endtask
   task automatic test_timer2();
      {pb_lo, pb_hi, pa_lo, remap, t23_en, t24_en} = {48'h9444_4449_4494, 8'hC0, 2'h3};
      {s1_mode, s1_spi} = {2'h2, 8'h10};
      for (int v = 0; v < 2; v++) begin
         {t23_o, t24_o, s1_sck} = {v[0], v[0], !v[0]};
         settle();
         chk("b3 timer", v[0], pad_out[b3]);
         chk("b3 capture", v[0], t23_i);
         chk("b4 timer", v[0], pad_out[b4]);
         chk("b4 capture", v[0], t24_i);
      end
      remap = 8'h00;
      settle();
      chk("b3 s1 clock", 1'b0, pad_out[b3]);
      chk("a1 timer", 1'b1, pad_out[a1]);
      chk("a1 capture", 1'b1, t23_i);
      {remap, t23_en, t23_o, s1_sck} = {8'h40, 3'h1};
      settle();
      chk("b3 s1 no en", 1'b1, pad_out[b3]);
      $display("test timer2 done");
   endtask
   task automatic test_sercon1();
      {s1_mode, s1_uart, remap, t24_en} = {2'h1, 8'h20, 8'h00, 1'b0};
      {pb_hi, ext_oe[b3]} = {16'h4449, 1'b1};
      for (int v = 0; v < 2; v++) begin
         {s1_rts, ext_val[b3]} = {v[0], !v[0]};
         settle();
         chk("s1 rts", v[0], pad_out[b4]);
         chk("s1 cts", !v[0], s1_cts);
      end
      {s1_mode, s1_spi, pb_hi, ext_oe[b4], ext_val[b4]} = {2'h2, 8'h00, 16'h4444, 2'h3};
      settle();
      chk("s1 ssel high", 1'b1, s1_ss);
      {ext_val[b4], ext_val[b3]} = 2'h1;
      settle();
      chk("s1 ssel low", 1'b0, s1_ss);
      chk("s1 sck in", 1'b1, s1_scki);
      $display("test sercon1 done");
   endtask
   task automatic test_irq();
      ext_oe = 32'hFFFF_FFFF;
      for (int p = 2; p < 31; p += 9) begin
         {sel_c, sel_d, ext_val} = {p[4:0], 5'(p + 1), 32'h0000_0001 << p};
         settle();
         chk("irq c", 1'b1, irq_c);
         chk("irq d", 1'b0, irq_d);
      end
      sel_d = 5'h1D;
      settle();
      chk("irq d high", 1'b1, irq_d);
      {clk_en, ext_val} = {1'b0, 32'h0000_0000};
      settle();
      chk("irq c held", 1'b1, irq_c);
      clk_en = 1'b1;
      settle();
      chk("irq c low", 1'b0, irq_c);
      $display("test irq done");
   endtask
   // ------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      {mismatches, tests_run, reset_n, clk_en, reg_en} = {64'h0, 3'h2};
      defaults();
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
      settle();
      test_regulator();
      defaults();
      test_timer1();
      defaults();
      test_sercon3_spi();
      defaults();
      test_sercon3_uart_twi();
      defaults();
      test_timer2();
      defaults();
      test_sercon1();
      defaults();
      test_irq();
      end_of_test();
   end
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      end_of_test();
   end
endmodule
`default_nettype wire
